//--- design/pixel_block_engine_addressing.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_block_engine_addressing (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic [23:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic [31:0]      reg_rdata_o,
	input  wire logic        start_i,
	input  wire logic        copy_i,
	input  wire logic        swap_roles_i,
	input  wire logic [15:0] inner_len_i,
	input  wire logic [15:0] outer_len_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [31:0]      dest_addr_o,
	output logic [31:0]      src_addr_o,
	output logic             dest_we_o,
	output logic             src_re_o,
	output logic             write_inhibit_o,
	output logic [6:0]       pixels_per_beat_o
);

	// ************************************************************
	// Register decode
	// ************************************************************
	function automatic logic [4:0] reg_index(input logic [23:0] a);
		logic [23:0] off;
		off = a - pbe_pkg::REG_BLOCK_BASE;
		if (off[1:0] == 2'h0 && off[23:2] < 22'(pbe_pkg::REG_COUNT)) begin
			return {1'b1, off[5:2]};
		end
		return 5'h00;
	endfunction

	logic [31:0]         regs [0:13];
	pbe_pkg::seq_state_t state;
	pbe_pkg::seq_state_t next_state;
	logic [15:0]         inner_rem;
	logic [15:0]         outer_rem;
	logic [15:0]         inner_len;
	logic                copy_mode;
	logic                swap_mode;
	logic [4:0]          wr_sel;
	logic [4:0]          rd_sel;

	assign wr_sel = reg_index(reg_addr_i);
	assign rd_sel = reg_index(reg_addr_i);

	// ************************************************************
	// Address units
	// ************************************************************
	pbe_pkg::flags_t dest_flags;
	pbe_pkg::flags_t src_flags;
	pbe_pkg::ptr_t   dest_ptr;
	pbe_pkg::ptr_t   dest_frac;
	pbe_pkg::ptr_t   src_ptr;
	logic [31:0]     dest_unit_addr;
	logic [31:0]     src_unit_addr;
	logic            dest_width_ok;
	logic            src_width_ok;
	logic            dest_outside;

	assign dest_flags = pbe_pkg::flags_t'(regs[pbe_pkg::IDX_DEST_FLAGS]);
	assign src_flags  = pbe_pkg::flags_t'(regs[pbe_pkg::IDX_SRC_FLAGS]);
	assign dest_ptr   = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_PIXEL]);
	assign dest_frac  = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_FPIXEL]);
	assign src_ptr    = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_SRC_PIXEL]);

	pbe_addr_gen dest_address_unit (
		.base_i     (regs[pbe_pkg::IDX_DEST_BASE]),
		.flags_i    (dest_flags),
		.ptr_i      (dest_ptr),
		.mask_i     (pbe_pkg::MASK_NONE),
		.addr_o     (dest_unit_addr),
		.width_ok_o (dest_width_ok)
	);

	pbe_addr_gen src_address_unit (
		.base_i     (regs[pbe_pkg::IDX_SRC_BASE]),
		.flags_i    (src_flags),
		.ptr_i      (src_ptr),
		.mask_i     (regs[pbe_pkg::IDX_SRC_MASK]),
		.addr_o     (src_unit_addr),
		.width_ok_o (src_width_ok)
	);

	pbe_clip_check dest_clip (
		.ptr_i     (dest_ptr),
		.size_i    (pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_CLIP])),
		.outside_o (dest_outside)
	);

	// ************************************************************
	// Pointer update
	// ************************************************************
	logic [6:0]    dest_ppp;
	logic [6:0]    src_ppp;
	logic [6:0]    dest_adv;
	logic [6:0]    src_adv;
	logic [6:0]    role_adv;
	logic          eol;
	logic          inhibit;
	logic [31:0]   sum_x;
	logic [31:0]   sum_y;
	pbe_pkg::ptr_t dest_step;
	pbe_pkg::ptr_t dest_fstep;
	pbe_pkg::ptr_t dest_inc;
	pbe_pkg::ptr_t dest_finc;
	pbe_pkg::ptr_t src_step;
	pbe_pkg::ptr_t next_dest_ptr;
	pbe_pkg::ptr_t next_dest_frac;
	pbe_pkg::ptr_t next_src_ptr;

	assign dest_step  = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_STEP]);
	assign dest_fstep = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_FSTEP]);
	assign dest_inc   = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_INC]);
	assign dest_finc  = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_DEST_FINC]);
	assign src_step   = pbe_pkg::ptr_t'(regs[pbe_pkg::IDX_SRC_STEP]);

	// phrase holds 64 bits of pixels
	assign dest_ppp = pbe_pkg::pixels_per_phrase(dest_flags.psize);
	assign src_ppp  = pbe_pkg::pixels_per_phrase(src_flags.psize);

	always_comb begin
		if (dest_flags.upd == pbe_pkg::UPD_PHRASE) begin
			dest_adv = dest_ppp - (dest_ptr.x[6:0] & (dest_ppp - 7'h01));
		end else begin
			dest_adv = 7'h01;
		end
		if (src_flags.upd == pbe_pkg::UPD_PHRASE) begin
			src_adv = src_ppp - (src_ptr.x[6:0] & (src_ppp - 7'h01));
		end else begin
			src_adv = 7'h01;
		end
	end

	assign role_adv = swap_mode ? src_adv : dest_adv;
	assign eol      = inner_rem <= {9'h000, role_adv};

	always_comb begin
		next_dest_ptr  = dest_ptr;
		next_dest_frac = dest_frac;
		next_src_ptr   = src_ptr;
		sum_x          = 32'h00000000;
		sum_y          = 32'h00000000;
		if (eol) begin
			sum_x = pbe_pkg::add_fixed(dest_ptr.x, dest_frac.x,
				dest_step.x, dest_fstep.x);
			sum_y = pbe_pkg::add_fixed(dest_ptr.y, dest_frac.y,
				dest_step.y, dest_fstep.y);
			next_dest_ptr  = {sum_y[31:16], sum_x[31:16]};
			next_dest_frac = {sum_y[15:0], sum_x[15:0]};
			next_src_ptr.x = src_ptr.x + src_step.x;
			next_src_ptr.y = src_ptr.y + src_step.y;
		end else begin
			if (dest_flags.upd == pbe_pkg::UPD_DDA) begin
				sum_x = pbe_pkg::add_fixed(dest_ptr.x, dest_frac.x,
					dest_inc.x, dest_finc.x);
				sum_y = pbe_pkg::add_fixed(dest_ptr.y, dest_frac.y,
					dest_inc.y, dest_finc.y);
				next_dest_ptr  = {sum_y[31:16], sum_x[31:16]};
				next_dest_frac = {sum_y[15:0], sum_x[15:0]};
			end else begin
				next_dest_ptr.x = dest_ptr.x + {9'h000, dest_adv};
			end
			next_src_ptr.x = src_ptr.x + {9'h000, src_adv};
		end
	end

	assign inhibit = (swap_mode ? !src_width_ok : !dest_width_ok) ||
		(!swap_mode && dest_flags.clip_en && dest_outside);

	// ************************************************************
	// Register file
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 14; i++) begin
				regs[i] <= pbe_pkg::REG_RESET;
			end
		end else if (state == pbe_pkg::ST_IDLE) begin
			if (reg_we_i && wr_sel[4]) begin
				regs[wr_sel[3:0]] <= reg_wdata_i;
			end
		end else if (state == pbe_pkg::ST_RUN) begin
			regs[pbe_pkg::IDX_DEST_PIXEL]  <= next_dest_ptr;
			regs[pbe_pkg::IDX_DEST_FPIXEL] <= next_dest_frac;
			regs[pbe_pkg::IDX_SRC_PIXEL]   <= next_src_ptr;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_re_i) begin
			reg_rdata_o <= rd_sel[4] ? regs[rd_sel[3:0]] : 32'h00000000;
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	// inner scan then outer step
	always_comb begin
		next_state = state;
		unique case (state)
			pbe_pkg::ST_IDLE: begin
				if (start_i) begin
					if (inner_len_i == 16'h0000 || outer_len_i == 16'h0000) begin
						next_state = pbe_pkg::ST_DONE;
					end else begin
						next_state = pbe_pkg::ST_RUN;
					end
				end
			end
			pbe_pkg::ST_RUN: begin
				if (eol && outer_rem == 16'h0001) begin
					next_state = pbe_pkg::ST_DONE;
				end
			end
			pbe_pkg::ST_DONE: begin
				next_state = pbe_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state     <= pbe_pkg::ST_IDLE;
			inner_rem <= 16'h0000;
			outer_rem <= 16'h0000;
			inner_len <= 16'h0000;
			copy_mode <= 1'b0;
			swap_mode <= 1'b0;
		end else begin
			state <= next_state;
			if (state == pbe_pkg::ST_IDLE && start_i) begin
				inner_rem <= inner_len_i;
				inner_len <= inner_len_i;
				outer_rem <= outer_len_i;
				copy_mode <= copy_i;
				swap_mode <= swap_roles_i;
			end else if (state == pbe_pkg::ST_RUN) begin
				if (eol) begin
					inner_rem <= inner_len;
					outer_rem <= outer_rem - 16'h0001;
				end else begin
					inner_rem <= inner_rem - {9'h000, role_adv};
				end
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			busy_o            <= 1'b0;
			done_o            <= 1'b0;
			dest_addr_o       <= 32'h00000000;
			src_addr_o        <= 32'h00000000;
			dest_we_o         <= 1'b0;
			src_re_o          <= 1'b0;
			write_inhibit_o   <= 1'b0;
			pixels_per_beat_o <= 7'h00;
		end else begin
			busy_o <= next_state != pbe_pkg::ST_IDLE;
			done_o <= next_state == pbe_pkg::ST_DONE;
			dest_addr_o <= swap_mode ? src_unit_addr : dest_unit_addr;
			src_addr_o  <= swap_mode ? dest_unit_addr : src_unit_addr;
			dest_we_o   <= state == pbe_pkg::ST_RUN;
			src_re_o    <= state == pbe_pkg::ST_RUN && copy_mode;
			write_inhibit_o <= state == pbe_pkg::ST_RUN && inhibit;
			pixels_per_beat_o <= state == pbe_pkg::ST_RUN ? role_adv : 7'h00;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	write_blocked_busy_a: assert property (
		state != pbe_pkg::ST_IDLE && reg_we_i &&
		reg_addr_i == pbe_pkg::DEST_BASE_OFS
		|=> $stable(regs[pbe_pkg::IDX_DEST_BASE]))
		else $error("register changed while busy");

	start_to_beat_a: assert property (
		state == pbe_pkg::ST_IDLE && start_i &&
		inner_len_i != 16'h0000 && outer_len_i != 16'h0000
		|=> busy_o ##1 dest_we_o)
		else $error("start did not begin a run");

	done_ends_busy_a: assert property (
		done_o |-> busy_o ##1 (!busy_o && !done_o))
		else $error("done pulse not ending busy");

	pixel_step_a: assert property (
		state == pbe_pkg::ST_RUN && !eol &&
		dest_flags.upd == pbe_pkg::UPD_PIXEL
		|=> dest_ptr.x == $past(dest_ptr.x) + 16'h0001)
		else $error("pixel pointer did not advance by one");

	width_exp_check_a: assert property (
		state == pbe_pkg::ST_RUN && !swap_mode &&
		dest_flags.wexp > pbe_pkg::WIDTH_EXP_MAX
		|=> write_inhibit_o)
		else $error("bad width exponent not inhibited");

	clip_negative_a: assert property (
		state == pbe_pkg::ST_RUN && !swap_mode && dest_flags.clip_en &&
		dest_ptr.x[15]
		|=> write_inhibit_o && dest_we_o)
		else $error("out of window write not clipped");

	role_swap_addr_a: assert property (
		state == pbe_pkg::ST_RUN && swap_mode
		|=> dest_addr_o == $past(src_unit_addr))
		else $error("swapped role address wrong");

	quad_pixel_beat_a: assert property (
		state == pbe_pkg::ST_RUN && !swap_mode &&
		dest_flags.psize == pbe_pkg::PSIZE_16 &&
		dest_flags.upd == pbe_pkg::UPD_PHRASE && dest_ptr.x[1:0] == 2'h0
		|=> pixels_per_beat_o == 7'h04)
		else $error("16 bpp phrase beat not four pixels");

	run_done_c: cover property (done_o);
	swap_copy_c: cover property (
		state == pbe_pkg::ST_RUN && swap_mode && copy_mode);
	clip_beat_c: cover property (dest_we_o && write_inhibit_o);

endmodule
`default_nettype wire

//--- design/pbe_pkg.sv
`default_nettype none
package pbe_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [23:0] REG_BLOCK_BASE  = 24'hF02200;
	localparam logic [23:0] DEST_BASE_OFS   = 24'hF02200;
	localparam logic [23:0] DEST_FLAGS_OFS  = 24'hF02204;
	localparam logic [23:0] DEST_CLIP_OFS   = 24'hF02208;
	localparam logic [23:0] DEST_PIXEL_OFS  = 24'hF0220C;
	localparam logic [23:0] DEST_STEP_OFS   = 24'hF02210;
	localparam logic [23:0] DEST_FSTEP_OFS  = 24'hF02214;
	localparam logic [23:0] DEST_FPIXEL_OFS = 24'hF02218;
	localparam logic [23:0] DEST_INC_OFS    = 24'hF0221C;
	localparam logic [23:0] DEST_FINC_OFS   = 24'hF02220;
	localparam logic [23:0] SRC_BASE_OFS    = 24'hF02224;
	localparam logic [23:0] SRC_FLAGS_OFS   = 24'hF02228;
	localparam logic [23:0] SRC_MASK_OFS    = 24'hF0222C;
	localparam logic [23:0] SRC_PIXEL_OFS   = 24'hF02230;
	localparam logic [23:0] SRC_STEP_OFS    = 24'hF02234;
	localparam logic [4:0]  REG_COUNT       = 5'h0E;

	localparam logic [3:0] IDX_DEST_BASE   = 4'h0;
	localparam logic [3:0] IDX_DEST_FLAGS  = 4'h1;
	localparam logic [3:0] IDX_DEST_CLIP   = 4'h2;
	localparam logic [3:0] IDX_DEST_PIXEL  = 4'h3;
	localparam logic [3:0] IDX_DEST_STEP   = 4'h4;
	localparam logic [3:0] IDX_DEST_FSTEP  = 4'h5;
	localparam logic [3:0] IDX_DEST_FPIXEL = 4'h6;
	localparam logic [3:0] IDX_DEST_INC    = 4'h7;
	localparam logic [3:0] IDX_DEST_FINC   = 4'h8;
	localparam logic [3:0] IDX_SRC_BASE    = 4'h9;
	localparam logic [3:0] IDX_SRC_FLAGS   = 4'hA;
	localparam logic [3:0] IDX_SRC_MASK    = 4'hB;
	localparam logic [3:0] IDX_SRC_PIXEL   = 4'hC;
	localparam logic [3:0] IDX_SRC_STEP    = 4'hD;

	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [31:0] MASK_NONE = 32'hFFFFFFFF;

	// ************************************************************
	// Field encodings
	// ************************************************************
	localparam logic [3:0] WIDTH_EXP_MAX = 4'hB;
	localparam logic [2:0] PSIZE_16      = 3'h4;
	localparam logic [2:0] PSIZE_MAX     = 3'h5;
	localparam logic [1:0] UPD_PIXEL     = 2'h0;
	localparam logic [1:0] UPD_PHRASE    = 2'h1;
	localparam logic [1:0] UPD_DDA       = 2'h2;
	localparam logic [6:0] PHRASE_PIXELS_1BPP = 7'h40;

	typedef struct packed {
		logic [15:0] y;
		logic [15:0] x;
	} ptr_t;

	typedef struct packed {
		logic [18:0] rsvd;
		logic        mask_en;
		logic [1:0]  upd;
		logic        clip_en;
		logic [3:0]  wexp;
		logic [1:0]  wmant;
		logic [2:0]  psize;
	} flags_t;

	typedef enum {ST_IDLE, ST_RUN, ST_DONE} seq_state_t;

	// Pixels in one 64-bit phrase
	function automatic logic [6:0] pixels_per_phrase(
		input logic [2:0] psize);
		return PHRASE_PIXELS_1BPP >> psize;
	endfunction

	// Width is 1.mm x 2^exp
	function automatic logic [16:0] decode_width(input logic [3:0] e,
		input logic [1:0] m);
		logic [19:0] w;
		w = 20'({1'b1, m}) << e;
		return w[18:2];
	endfunction

	// Integer.fraction sum with wrap
	function automatic logic [31:0] add_fixed(input logic [15:0] ai,
		input logic [15:0] af, input logic [15:0] bi,
		input logic [15:0] bf);
		return {ai, af} + {bi, bf};
	endfunction

endpackage
`default_nettype wire

//--- design/pbe_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pbe_addr_gen (
	input  wire logic [31:0]     base_i,
	input  wire pbe_pkg::flags_t flags_i,
	input  wire pbe_pkg::ptr_t   ptr_i,
	input  wire logic [31:0]     mask_i,
	output logic [31:0]          addr_o,
	output logic                 width_ok_o
);
	pbe_pkg::ptr_t eff;
	logic [16:0]   width;
	logic [35:0]   offset;

	always_comb begin
		eff = ptr_i;
		if (flags_i.mask_en) begin
			eff.y = ptr_i.y & mask_i[31:16];
			eff.x = ptr_i.x & mask_i[15:0];
		end
	end

	assign width = pbe_pkg::decode_width(flags_i.wexp, flags_i.wmant);
	assign width_ok_o = (flags_i.wexp <= pbe_pkg::WIDTH_EXP_MAX) &&
		(flags_i.psize <= pbe_pkg::PSIZE_MAX);

	assign offset = (36'(eff.y[11:0]) * 36'(width) + 36'(eff.x))
		<< flags_i.psize;
	assign addr_o = base_i + offset[34:3];
endmodule
`default_nettype wire

//--- design/pbe_clip_check.sv
`timescale 1ns/1ps
`default_nettype none
module pbe_clip_check (
	input  wire pbe_pkg::ptr_t ptr_i,
	input  wire pbe_pkg::ptr_t size_i,
	output logic               outside_o
);
	assign outside_o = ptr_i.x[15] || ptr_i.y[15] ||
		(ptr_i.x >= size_i.x) || (ptr_i.y >= size_i.y);
endmodule
`default_nettype wire

//--- dv/pbe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbe_host_model (
	input  wire logic        clk_sys_i,
	output logic [23:0]      reg_addr_o,
	output logic [31:0]      reg_wdata_o,
	output logic             reg_we_o,
	output logic             reg_re_o,
	input  wire logic [31:0] reg_rdata_i
);
	initial begin
		reg_addr_o  = 24'h000000;
		reg_wdata_o = 32'h00000000;
		reg_we_o    = 1'b0;
		reg_re_o    = 1'b0;
	end

	task automatic write_reg(input logic [23:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_we_o    <= 1'b1;
		@(posedge clk_sys_i);
		reg_we_o    <= 1'b0;
		reg_wdata_o <= ~d;
	endtask

	task automatic read_reg(input logic [23:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_re_o   <= 1'b1;
		@(posedge clk_sys_i);
		reg_re_o <= 1'b0;
		#1;
		d = reg_rdata_i;
	endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_sys_i;
	logic        rst_n_i;
	logic        start_i;
	logic        copy_i;
	logic        swap_roles_i;
	logic [15:0] inner_len_i;
	logic [15:0] outer_len_i;
	wire  [23:0] reg_addr;
	wire  [31:0] reg_wdata;
	wire         reg_we;
	wire         reg_re;
	logic [31:0] reg_rdata_o;
	logic        busy_o;
	logic        done_o;
	logic [31:0] dest_addr_o;
	logic [31:0] src_addr_o;
	logic        dest_we_o;
	logic        src_re_o;
	logic        write_inhibit_o;
	logic [6:0]  pixels_per_beat_o;
	int          errors;
	int          num_checks;
	int          beats;
	logic [31:0] rd;

	pixel_block_engine_addressing uut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata_o),
		.start_i(start_i), .copy_i(copy_i), .swap_roles_i(swap_roles_i),
		.inner_len_i(inner_len_i), .outer_len_i(outer_len_i),
		.busy_o(busy_o), .done_o(done_o), .dest_addr_o(dest_addr_o),
		.src_addr_o(src_addr_o), .dest_we_o(dest_we_o), .src_re_o(src_re_o),
		.write_inhibit_o(write_inhibit_o),
		.pixels_per_beat_o(pixels_per_beat_o));

	pbe_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re),
		.reg_rdata_i(reg_rdata_o));

	// ************************************************************
	// Clock, beat counter, helpers
	// ************************************************************
	initial clk_sys_i = 1'b0;
	always #10 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		if (dest_we_o === 1'b1)
			beats <= beats + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [31:0] mkflags(input logic [2:0] p,
		input logic [3:0] e, input logic [1:0] m, input logic c,
		input logic [1:0] u);
		return {19'h00000, 1'b0, u, c, e, m, p};
	endfunction

	// Base + ((Y mod 4096) * width + X) pixels, in bytes
	function automatic logic [31:0] calc_addr(input logic [31:0] base,
		input logic [2:0] p, input logic [3:0] e, input logic [1:0] m,
		input logic [15:0] x, input logic [15:0] y);
		logic [47:0] off;
		off = (48'(y & 16'h0FFF) * ((48'({1'b1, m}) << e) >> 2)
			+ 48'(x)) << p;
		return base + 32'(off >> 3);
	endfunction

	task automatic prog_dest(input logic [31:0] base, input logic [31:0] fl,
		input logic [15:0] x, input logic [15:0] y, input logic [31:0] clip);
		host.write_reg(pbe_pkg::DEST_BASE_OFS, base);
		host.write_reg(pbe_pkg::DEST_FLAGS_OFS, fl);
		host.write_reg(pbe_pkg::DEST_CLIP_OFS, clip);
		host.write_reg(pbe_pkg::DEST_PIXEL_OFS, {y, x});
	endtask

	task automatic prog_src(input logic [31:0] base, input logic [31:0] fl,
		input logic [15:0] x, input logic [15:0] y);
		host.write_reg(pbe_pkg::SRC_BASE_OFS, base);
		host.write_reg(pbe_pkg::SRC_FLAGS_OFS, fl);
		host.write_reg(pbe_pkg::SRC_MASK_OFS, pbe_pkg::MASK_NONE);
		host.write_reg(pbe_pkg::SRC_PIXEL_OFS, {y, x});
	endtask

	// Returns just after the edge that takes the start
	task automatic go(input logic c, input logic s, input logic [15:0] il,
		input logic [15:0] ol);
		@(posedge clk_sys_i);
		start_i      <= 1'b1;
		copy_i       <= c;
		swap_roles_i <= s;
		inner_len_i  <= il;
		outer_len_i  <= ol;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		#1;
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 60 && busy_o !== 1'b0; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		check(32'(busy_o), 32'h00000000);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs;
		logic [23:0] a;
		for (int i = 0; i < 14; i++) begin
			a = 24'hF02200 + 24'(4 * i);
			host.read_reg(a, rd);
			check(rd, pbe_pkg::REG_RESET);
			host.write_reg(a, 32'h5A5A0000 + 32'(i));
			host.read_reg(a, rd);
			check(rd, 32'h5A5A0000 + 32'(i));
			host.write_reg(a, 32'h00000000);
		end
		host.read_reg(24'hF02238, rd);
		check(rd, 32'h00000000);
		host.read_reg(24'hF02202, rd);
		check(rd, 32'h00000000);
	endtask

	task automatic t_rect;
		prog_dest(32'h00001000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
			pbe_pkg::UPD_PIXEL), 16'h0003, 16'h1002, 32'h00000000);
		go(1'b0, 1'b0, 16'h0002, 16'h0001);
		check(32'(busy_o), 32'h00000001);
		@(posedge clk_sys_i);
		#1;
		check({dest_we_o, src_re_o, done_o}, 32'h00000004);
		check(dest_addr_o, 32'h00001023);
		check(32'(pixels_per_beat_o), 32'h00000001);
		@(posedge clk_sys_i);
		#1;
		check(dest_addr_o, 32'h00001024);
		check(32'(done_o), 32'h00000001);
		@(posedge clk_sys_i);
		#1;
		check({busy_o, dest_we_o}, 32'h00000000);
	endtask

	task automatic t_sizes;
		for (int p = 0; p < 6; p++) begin
			prog_dest(32'h00002000, mkflags(3'(p), 4'h6, 2'h0, 1'b0,
				pbe_pkg::UPD_PHRASE), 16'h0000, 16'h0001, 32'h00000000);
			go(1'b0, 1'b0, 16'h0001, 16'h0001);
			@(posedge clk_sys_i);
			#1;
			check(dest_addr_o, calc_addr(32'h00002000, 3'(p), 4'h6, 2'h0,
				16'h0000, 16'h0001));
			check(32'(pixels_per_beat_o), 32'h40 >> p);
			wait_idle;
		end
	endtask

	task automatic t_clip;
		logic [15:0] xs[5] = '{16'h0001, 16'h0004, 16'hFFFF, 16'h0004,
			16'h0000};
		logic        cl[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		logic [3:0]  ex[5] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'hC};
		logic        inh[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			prog_dest(32'h00003000, mkflags(pbe_pkg::PSIZE_16, ex[i], 2'h0,
				cl[i], pbe_pkg::UPD_PIXEL), xs[i], 16'h0000, 32'h00040004);
			go(1'b0, 1'b0, 16'h0001, 16'h0001);
			@(posedge clk_sys_i);
			#1;
			check({dest_we_o, write_inhibit_o}, {31'h1, inh[i]});
			wait_idle;
		end
	endtask

	task automatic t_copy;
		for (int s = 0; s < 2; s++) begin
			prog_dest(32'h00001000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
				pbe_pkg::UPD_PIXEL), 16'h0000, 16'h0000, 32'h00000000);
			prog_src(32'h00008000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
				pbe_pkg::UPD_PIXEL), 16'h0002, 16'h0001);
			go(1'b1, 1'(s), 16'h0001, 16'h0001);
			@(posedge clk_sys_i);
			#1;
			check(32'(src_re_o), 32'h00000001);
			check(dest_addr_o, s ? 32'h00008012 : 32'h00001000);
			check(src_addr_o, s ? 32'h00001000 : 32'h00008012);
			wait_idle;
		end
	endtask

	task automatic t_busy;
		int b0;
		prog_dest(32'h00001000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
			pbe_pkg::UPD_PIXEL), 16'h0000, 16'h0000, 32'h00000000);
		b0 = beats;
		go(1'b0, 1'b0, 16'h0003, 16'h0002);
		host.write_reg(pbe_pkg::DEST_BASE_OFS, 32'hDEAD0000);
		@(posedge clk_sys_i);
		start_i <= 1'b1;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		#1;
		wait_idle;
		repeat (4) @(posedge clk_sys_i);
		#1;
		check(32'(beats - b0), 32'h00000006);
		host.read_reg(pbe_pkg::DEST_BASE_OFS, rd);
		check(rd, 32'h00001000);
		b0 = beats;
		go(1'b0, 1'b0, 16'h0000, 16'h0001);
		check(32'(done_o), 32'h00000001);
		wait_idle;
		check(32'(beats - b0), 32'h00000000);
	endtask

	// Stepped pointer with fraction, masked source
	task automatic t_modes;
		logic [31:0] da[3] = '{32'h00001000, 32'h00001001, 32'h00001003};
		logic [31:0] sa[3] = '{32'h00008021, 32'h00008022, 32'h00008023};
		prog_dest(32'h00001000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
			pbe_pkg::UPD_DDA), 16'h0000, 16'h0000, 32'h00000000);
		host.write_reg(pbe_pkg::DEST_INC_OFS, 32'h00000001);
		host.write_reg(pbe_pkg::DEST_FINC_OFS, 32'h00008000);
		host.write_reg(pbe_pkg::DEST_FSTEP_OFS, 32'h00004000);
		prog_src(32'h00008000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
			pbe_pkg::UPD_PIXEL) | 32'h00001000, 16'h0005, 16'h0006);
		host.write_reg(pbe_pkg::SRC_MASK_OFS, 32'h00030003);
		go(1'b1, 1'b0, 16'h0003, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_i);
			#1;
			check(dest_addr_o, da[i]);
			check(src_addr_o, sa[i]);
		end
		wait_idle;
		host.read_reg(pbe_pkg::DEST_PIXEL_OFS, rd);
		check(rd, 32'h00000003);
		host.read_reg(pbe_pkg::DEST_FPIXEL_OFS, rd);
		check(rd, 32'h00004000);
	endtask

	// Reset in the middle of a run
	task automatic t_reset;
		prog_dest(32'h00004000, mkflags(3'h3, 4'h4, 2'h0, 1'b0,
			pbe_pkg::UPD_PIXEL), 16'h0000, 16'h0000, 32'h00000000);
		go(1'b1, 1'b0, 16'h0008, 16'h0001);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		#1;
		check({busy_o, done_o, dest_we_o, src_re_o, write_inhibit_o},
			32'h00000000);
		check(dest_addr_o | src_addr_o | 32'(pixels_per_beat_o),
			32'h00000000);
		host.read_reg(pbe_pkg::DEST_BASE_OFS, rd);
		check(rd, pbe_pkg::REG_RESET);
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		errors       = 0;
		num_checks   = 0;
		rst_n_i      = 1'b0;
		start_i      = 1'b0;
		copy_i       = 1'b0;
		swap_roles_i = 1'b0;
		inner_len_i  = 16'h0000;
		outer_len_i  = 16'h0000;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_regs;
		t_rect;
		t_sizes;
		t_clip;
		t_copy;
		t_busy;
		t_modes;
		t_reset;
		wrap_up;
	end

	initial begin
		#100000;
		errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
